// *** logic/scp_serial_port.sv ***
// Serial control port with buffered and active register copies.
`timescale 1ns/1ps

module scp_serial_port #(
  parameter int REG_COUNT = scp_pkg::REG_COUNT
) (
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  input  wire logic       CS_N,
  input  wire logic       SCLK,
  input  wire logic       SDIO_IN,
  output logic            SDIO_OUT,
  output logic            SDIO_OE,
  output logic            READBACK_OUT_LINE,
  output logic            READBACK_OUT_LINE_OE,
  input  wire logic [9:0] ACT_ADDR,
  output logic      [7:0] ACT_DATA,
  output logic            UPDATE_PULSE
);

  if (REG_COUNT <= int'(scp_pkg::ADDR_TOP)) begin : g_count_check
    $error("REG_COUNT must cover the top address.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  scp_pkg::scp_pins_t pins_s1_reg;
  scp_pkg::scp_pins_t pins_s2_reg;
  scp_pkg::scp_pins_t pins_s3_reg;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pins_s1_reg <= '{cs_n: 1'b1, sclk: 1'b0, sdio: 1'b0};
      pins_s2_reg <= '{cs_n: 1'b1, sclk: 1'b0, sdio: 1'b0};
      pins_s3_reg <= '{cs_n: 1'b1, sclk: 1'b0, sdio: 1'b0};
    end else begin
      pins_s1_reg <= '{cs_n: CS_N, sclk: SCLK, sdio: SDIO_IN};
      pins_s2_reg <= pins_s1_reg;
      pins_s3_reg <= pins_s2_reg;
    end
  end

  logic cs_low;
  logic cs_rise;
  logic sclk_rise;
  logic din;

  assign cs_low    = !pins_s2_reg.cs_n;
  assign cs_rise   = pins_s2_reg.cs_n && !pins_s3_reg.cs_n;
  assign sclk_rise = pins_s2_reg.sclk && !pins_s3_reg.sclk && cs_low;
  assign din       = pins_s2_reg.sdio;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing.

  scp_pkg::scp_state_t state_reg;
  logic [3:0]          cnt_reg;
  logic [15:0]         instr_reg;
  logic [7:0]          sh_in_reg;
  logic [7:0]          sh_out_reg;
  logic [1:0]          bytes_left_reg;
  logic [9:0]          addr_reg;
  logic                rd_reg;
  logic                stream_reg;
  logic [7:0]          cfg_reg;
  logic                lsb_first;
  logic [15:0]         instr_next;
  logic [7:0]          sh_in_next;
  scp_pkg::scp_instr_t instr_dec;
  logic                instr_done;
  logic                byte_done;
  logic                last_byte;
  logic [9:0]          addr_step;
  logic [9:0]          rd_addr;
  logic [7:0]          rd_data;

  assign lsb_first  = cfg_reg[scp_pkg::CFG_LSB_BIT];
  assign instr_next = lsb_first ? {din, instr_reg[15:1]} : {instr_reg[14:0], din};
  assign sh_in_next = lsb_first ? {din, sh_in_reg[7:1]} : {sh_in_reg[6:0], din};
  assign instr_dec  = scp_pkg::scp_instr_t'(instr_next);
  assign instr_done = sclk_rise && (state_reg inside {scp_pkg::ST_IDLE, scp_pkg::ST_INSTR})
                      && cnt_reg == scp_pkg::CNT_INSTR_LAST;
  assign byte_done  = sclk_rise && state_reg == scp_pkg::ST_DATA
                      && cnt_reg == scp_pkg::CNT_BYTE_LAST;
  assign last_byte  = stream_reg ? (addr_reg == scp_pkg::ADDR_TOP)
                                 : (bytes_left_reg == 2'h0);

  always_comb begin
    if (lsb_first) begin
      addr_step = (addr_reg == scp_pkg::ADDR_TOP) ? scp_pkg::ADDR_TOP
                                                  : addr_reg + 10'h001;
    end else begin
      addr_step = (addr_reg == scp_pkg::ADDR_CFG) ? scp_pkg::ADDR_TOP
                                                  : addr_reg - 10'h001;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg      <= scp_pkg::ST_IDLE;
      cnt_reg        <= 4'h0;
      instr_reg      <= 16'h0000;
      sh_in_reg      <= 8'h00;
      bytes_left_reg <= 2'h0;
      addr_reg       <= 10'h000;
      rd_reg         <= 1'b0;
      stream_reg     <= 1'b0;
    end else if (cs_rise) begin
      if (cnt_reg[2:0] != 3'h0 || state_reg == scp_pkg::ST_DONE || stream_reg) begin
        state_reg  <= scp_pkg::ST_IDLE;
        cnt_reg    <= 4'h0;
        stream_reg <= 1'b0;
      end
    end else if (instr_done) begin
      state_reg      <= scp_pkg::ST_DATA;
      cnt_reg        <= 4'h0;
      instr_reg      <= instr_next;
      rd_reg         <= instr_dec.rd;
      stream_reg     <= instr_dec.length_code == scp_pkg::LEN_STREAM;
      bytes_left_reg <= instr_dec.length_code;
      addr_reg       <= instr_dec.start_address_bits[9:0];
    end else if (sclk_rise && state_reg != scp_pkg::ST_DATA) begin
      if (state_reg != scp_pkg::ST_DONE) begin
        state_reg <= scp_pkg::ST_INSTR;
        instr_reg <= instr_next;
        cnt_reg   <= cnt_reg + 4'h1;
      end
    end else if (byte_done) begin
      cnt_reg   <= 4'h0;
      sh_in_reg <= sh_in_next;
      if (last_byte) begin
        state_reg <= scp_pkg::ST_DONE;
      end else begin
        addr_reg <= addr_step;
        if (!stream_reg) begin
          bytes_left_reg <= bytes_left_reg - 2'h1;
        end
      end
    end else if (sclk_rise) begin
      cnt_reg   <= cnt_reg + 4'h1;
      sh_in_reg <= sh_in_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffered and active register copies.

  logic [7:0] buf_mem [REG_COUNT];
  logic [7:0] act_mem [REG_COUNT];
  logic       wr_fire;
  logic       upd_pend_reg;
  logic       srst_reg;

  assign wr_fire = byte_done && !rd_reg && addr_reg <= scp_pkg::ADDR_TOP;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_reg <= scp_pkg::CFG_RESET;
    end else if (wr_fire && addr_reg == scp_pkg::ADDR_CFG) begin
      cfg_reg <= sh_in_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      upd_pend_reg <= 1'b0;
      srst_reg     <= 1'b0;
    end else begin
      upd_pend_reg <= wr_fire && addr_reg == scp_pkg::ADDR_UPDATE
                      && sh_in_next[scp_pkg::UPD_BIT];
      srst_reg     <= wr_fire && addr_reg == scp_pkg::ADDR_CFG
                      && sh_in_next[scp_pkg::CFG_SRST_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        buf_mem[i] <= 8'h00;
        act_mem[i] <= 8'h00;
      end
    end else if (srst_reg) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        buf_mem[i] <= 8'h00;
        act_mem[i] <= 8'h00;
      end
    end else begin
      if (upd_pend_reg) begin
        for (int i = 0; i < REG_COUNT; i++) begin
          act_mem[i] <= buf_mem[i];
        end
      end
      if (wr_fire && addr_reg != scp_pkg::ADDR_CFG && addr_reg != scp_pkg::ADDR_BLANK) begin
        if (addr_reg == scp_pkg::ADDR_UPDATE) begin
          buf_mem[addr_reg] <= sh_in_next & 8'hFE;
        end else begin
          buf_mem[addr_reg] <= sh_in_next;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback shifting and pin drive.

  logic drive;

  assign rd_addr = instr_done ? instr_dec.start_address_bits[9:0] : addr_step;
  assign drive   = cs_low && rd_reg && state_reg == scp_pkg::ST_DATA;

  always_comb begin
    if (rd_addr == scp_pkg::ADDR_CFG) begin
      rd_data = cfg_reg;
    end else if (rd_addr > scp_pkg::ADDR_TOP) begin
      rd_data = 8'h00;
    end else if (act_mem[scp_pkg::ADDR_RBCTL][scp_pkg::RBSRC_BIT]) begin
      rd_data = act_mem[rd_addr];
    end else begin
      rd_data = buf_mem[rd_addr];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sh_out_reg <= 8'h00;
    end else if (cs_rise) begin
      sh_out_reg <= sh_out_reg;
    end else if ((instr_done && instr_dec.rd) || (byte_done && rd_reg && !last_byte)) begin
      sh_out_reg <= rd_data;
    end else if (sclk_rise && state_reg == scp_pkg::ST_DATA) begin
      sh_out_reg <= lsb_first ? {1'b0, sh_out_reg[7:1]} : {sh_out_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SDIO_OUT             <= 1'b0;
      SDIO_OE              <= 1'b0;
      READBACK_OUT_LINE    <= 1'b0;
      READBACK_OUT_LINE_OE <= 1'b0;
      ACT_DATA             <= 8'h00;
      UPDATE_PULSE         <= 1'b0;
    end else begin
      SDIO_OUT             <= lsb_first ? sh_out_reg[0] : sh_out_reg[7];
      READBACK_OUT_LINE    <= lsb_first ? sh_out_reg[0] : sh_out_reg[7];
      SDIO_OE              <= drive && !cfg_reg[scp_pkg::CFG_SDO_BIT];
      READBACK_OUT_LINE_OE <= drive && cfg_reg[scp_pkg::CFG_SDO_BIT];
      ACT_DATA             <= (int'(ACT_ADDR) < REG_COUNT) ? act_mem[ACT_ADDR] : 8'h00;
      UPDATE_PULSE         <= upd_pend_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  logic [7:0] rbctl_buf_past;
  always_ff @(posedge SYS_CLK) begin
    rbctl_buf_past <= buf_mem[scp_pkg::ADDR_RBCTL];
  end

  a_cs_high_tristate: assert property (!cs_low |=> !SDIO_OE && !READBACK_OUT_LINE_OE)
    else $error("Data outputs driven while select is high.");
  a_partial_flush: assert property (cs_rise && cnt_reg[2:0] != 3'h0
                                    |=> state_reg == scp_pkg::ST_IDLE)
    else $error("Partial byte did not reset the port.");
  a_stall_hold: assert property (cs_rise && cnt_reg[2:0] == 3'h0 && !stream_reg
                                 && state_reg == scp_pkg::ST_DATA
                                 |=> state_reg == scp_pkg::ST_DATA && cnt_reg == 4'h0)
    else $error("Stall on byte boundary lost the transfer.");
  a_update_pulse: assert property (wr_fire && addr_reg == scp_pkg::ADDR_UPDATE && sh_in_next[0]
                                   |=> upd_pend_reg ##1 UPDATE_PULSE
                                   && buf_mem[scp_pkg::ADDR_UPDATE][0] == 1'b0)
    else $error("Update did not fire or did not self-clear.");
  a_update_atomic: assert property (upd_pend_reg && !srst_reg
                                    |=> act_mem[scp_pkg::ADDR_RBCTL] == rbctl_buf_past)
    else $error("Active copy differs from buffer after update.");
  a_bus_mode: assert property (SDIO_OE |-> !READBACK_OUT_LINE_OE)
    else $error("Both readback lines driven together.");
  a_lsb_immediate: assert property (wr_fire && addr_reg == scp_pkg::ADDR_CFG
                                    |=> lsb_first == $past(sh_in_next[6]))
    else $error("Bit order did not change at once.");
  a_addr_step: assert property (byte_done && !last_byte && !cs_rise
                                |=> addr_reg == $past(addr_step))
    else $error("Address did not step after a byte.");
  a_stream_stop: assert property (byte_done && stream_reg && addr_reg == scp_pkg::ADDR_TOP
                                  |=> state_reg == scp_pkg::ST_DONE)
    else $error("Streaming did not stop at the top address.");
  a_length_done: assert property (byte_done && !stream_reg && bytes_left_reg == 2'h0
                                  |=> state_reg == scp_pkg::ST_DONE)
    else $error("Fixed-length transfer did not end.");
  a_done_hold: assert property (state_reg == scp_pkg::ST_DONE && !cs_rise
                                |=> state_reg == scp_pkg::ST_DONE)
    else $error("Clocks after the last byte restarted the port.");
  a_read_enable: assert property (instr_done && instr_dec.rd && !cs_rise ##1 cs_low
                                  |=> SDIO_OE || READBACK_OUT_LINE_OE)
    else $error("Read did not enable a data output.");
  a_blank_stable: assert property (wr_fire && addr_reg == scp_pkg::ADDR_BLANK
                                   |=> $stable(buf_mem[scp_pkg::ADDR_BLANK]))
    else $error("Write to a blank location changed the buffer.");
  a_instr_capture: assert property (instr_done && !cs_rise |=> state_reg == scp_pkg::ST_DATA
                                    && addr_reg == $past(instr_dec.start_address_bits[9:0]))
    else $error("Instruction was not captured after sixteen clocks.");
  a_read_load: assert property (instr_done && instr_dec.rd && !cs_rise
                                |=> sh_out_reg == $past(rd_data))
    else $error("First read byte was not loaded.");

  c_write_update: cover property (upd_pend_reg ##1 UPDATE_PULSE);
  c_read_drive: cover property (drive ##1 SDIO_OE);
  c_stream_end: cover property (byte_done && stream_reg && last_byte);
  c_stall: cover property (cs_rise && state_reg == scp_pkg::ST_DATA && cnt_reg == 4'h0);
  c_soft_reset: cover property (srst_reg);

endmodule : scp_serial_port

// *** logic/scp_pkg.sv ***
// Constants and types shared by the serial control port.
package scp_pkg;

  localparam int          ADDR_W      = 10;
  localparam int          REG_COUNT   = 563;
  localparam int          INSTR_BITS  = 16;
  localparam int          BYTE_BITS   = 8;
  localparam logic [9:0]  ADDR_CFG    = 10'h000;
  localparam logic [9:0]  ADDR_BLANK  = 10'h001;
  localparam logic [9:0]  ADDR_RBCTL  = 10'h004;
  localparam logic [9:0]  ADDR_UPDATE = 10'h232;
  localparam logic [9:0]  ADDR_TOP    = 10'h232;
  localparam logic [7:0]  CFG_RESET   = 8'h18;
  localparam int          CFG_SDO_BIT = 7;
  localparam int          CFG_LSB_BIT = 6;
  localparam int          CFG_SRST_BIT = 5;
  localparam int          UPD_BIT     = 0;
  localparam int          RBSRC_BIT   = 0;
  localparam logic [1:0]  LEN_STREAM  = 2'h3;
  localparam logic [3:0]  CNT_INSTR_LAST = 4'hF;
  localparam logic [3:0]  CNT_BYTE_LAST  = 4'h7;

  typedef struct packed {
    logic        rd;
    logic [1:0]  length_code;
    logic [12:0] start_address_bits;
  } scp_instr_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdio;
  } scp_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA  = 2'b10,
    ST_DONE  = 2'b11
  } scp_state_t;

endpackage : scp_pkg

// *** dv/scp_host.sv ***
// Host model that masters the serial link of the control port.
`timescale 1ns/1ps

module scp_host (
  input  wire logic clk,
  input  wire logic sdio_in,
  input  wire logic sdo_in,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdio,
  output logic      sdio_oe
);
  logic lsb = 1'b0;
  logic sep = 1'b0;

  initial begin
    cs_n    = 1'b1;
    sclk    = 1'b0;
    sdio    = 1'b0;
    sdio_oe = 1'b0;
  end

  // Lowers select ahead of the first clock.
  task automatic start();
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : start

  // Shifts n bits and samples each read bit while the clock is still low.
  task automatic shift(input logic [15:0] v, input int n, input logic drive,
                       output logic [15:0] r);
    r = 16'h0000;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sclk    <= 1'b0;
      sdio_oe <= drive;
      sdio    <= lsb ? v[i] : v[n-1-i];
      repeat (4) @(posedge clk);
      if (lsb) r[i] = sep ? sdo_in : sdio_in;
      else r[n-1-i] = sep ? sdo_in : sdio_in;
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask : shift

  // Parks the clock low, releases the data line and raises select.
  task automatic stop();
    @(posedge clk);
    sclk    <= 1'b0;
    sdio_oe <= 1'b0;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : stop
endmodule : scp_host

// *** dv/scp_serial_port_bench.sv ***
// Self-checking bench for the serial control port.
`timescale 1ns/1ps

module scp_serial_port_bench;
  logic        sys_clk  = 1'b0;
  logic        rst_n    = 1'b0;
  logic [9:0]  act_addr = 10'h000;
  logic [7:0]  act_data;
  logic        sdio_out, sdio_oe, readback_out_line, sdo_oe, upd, cs_n, sclk, h_d, h_oe;
  logic        sdio_w, sdo_w, oe_seen;
  logic [31:0] rv;
  logic [15:0] t;
  int          num_errors  = 0;
  int          comparisons = 0;
  int          upd_cnt     = 0;
  int          cycles      = 0;

  assign sdio_w = sdio_oe ? sdio_out : (h_oe ? h_d : ~h_d);
  assign sdo_w  = sdo_oe ? readback_out_line : ~readback_out_line;

  scp_serial_port uut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .SDIO_IN(sdio_w),
    .SDIO_OUT(sdio_out), .SDIO_OE(sdio_oe), .READBACK_OUT_LINE(readback_out_line),
    .READBACK_OUT_LINE_OE(sdo_oe), .ACT_ADDR(act_addr), .ACT_DATA(act_data),
    .UPDATE_PULSE(upd)
  );

  scp_host host (
    .clk(sys_clk), .sdio_in(sdio_w), .sdo_in(sdo_w), .cs_n(cs_n), .sclk(sclk),
    .sdio(h_d), .sdio_oe(h_oe)
  );

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (upd === 1'b1) upd_cnt++;
    if (sdio_oe !== 1'b0) oe_seen = 1'b1;
    if (cycles == 40000) begin
      num_errors++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Runs one whole frame; byte k goes out of and comes back in bits 8k+7:8k.
  task automatic frame(input logic r, input logic [1:0] len, input logic [9:0] a,
                       input int n, input logic [31:0] wd);
    rv = 32'h0;
    host.start();
    host.shift({r, len, 3'h0, a}, 16, 1'b1, t);
    for (int k = 0; k < n; k++) begin
      host.shift({8'h00, wd[8*k+:8]}, 8, !r, t);
      rv[8*k+:8] = t[7:0];
    end
    host.stop();
    chk({sdio_oe, sdo_oe}, 32'h0);
  endtask : frame

  task automatic act_chk(input logic [9:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    act_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1 chk({24'h0, act_data}, {24'h0, e});
  endtask : act_chk

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_write_update();
    int n0;
    frame(1'b1, 2'b00, scp_pkg::ADDR_CFG, 1, 32'h0);
    chk(rv, {24'h0, scp_pkg::CFG_RESET});
    frame(1'b0, 2'b10, 10'h012, 3, 32'h00C3B2A1);
    act_chk(10'h012, 8'h00);
    n0 = upd_cnt;
    frame(1'b0, 2'b00, scp_pkg::ADDR_UPDATE, 1, 32'h01);
    chk(upd_cnt, n0 + 1);
    act_chk(10'h012, 8'hA1);
    act_chk(10'h011, 8'hB2);
    act_chk(10'h010, 8'hC3);
    frame(1'b1, 2'b00, scp_pkg::ADDR_UPDATE, 1, 32'h0);
    chk(rv, 32'h0);
    frame(1'b1, 2'b10, 10'h012, 3, 32'h0);
    chk(rv, 32'h00C3B2A1);
    $display("test write_update done");
  endtask : t_write_update

  task automatic t_stall_abort();
    host.start();
    host.shift(16'h2021, 16, 1'b1, t);
    host.stop();
    host.start();
    host.shift(16'h0044, 8, 1'b1, t);
    host.stop();
    host.start();
    host.shift(16'h0055, 8, 1'b1, t);
    host.stop();
    frame(1'b1, 2'b01, 10'h021, 2, 32'h0);
    chk(rv, 32'h5544);
    host.start();
    host.shift(16'h0030, 16, 1'b1, t);
    host.shift(16'h000F, 4, 1'b1, t);
    host.stop();
    host.start();
    host.shift(16'h0030, 16, 1'b1, t);
    host.stop();
    host.start();
    host.shift(16'h0007, 3, 1'b1, t);
    host.stop();
    frame(1'b1, 2'b00, 10'h030, 1, 32'h0);
    chk(rv, 32'h0);
    frame(1'b0, 2'b00, scp_pkg::ADDR_BLANK, 1, 32'hFF);
    frame(1'b1, 2'b00, scp_pkg::ADDR_BLANK, 1, 32'h0);
    chk(rv, 32'h0);
    $display("test stall_abort done");
  endtask : t_stall_abort

  task automatic t_stream();
    int n0;
    n0 = upd_cnt;
    frame(1'b0, 2'b11, scp_pkg::ADDR_BLANK, 4, 32'h77011833);
    chk(upd_cnt, n0 + 1);
    frame(1'b0, 2'b00, scp_pkg::ADDR_CFG, 1, 32'h5A);
    host.lsb = 1'b1;
    frame(1'b1, 2'b00, scp_pkg::ADDR_CFG, 1, 32'h0);
    chk(rv, 32'h5A);
    frame(1'b0, 2'b11, 10'h230, 4, 32'h99012211);
    chk(upd_cnt, n0 + 2);
    act_chk(10'h230, 8'h11);
    act_chk(10'h231, 8'h22);
    frame(1'b0, 2'b00, scp_pkg::ADDR_CFG, 1, 32'h18);
    host.lsb = 1'b0;
    $display("test stream done");
  endtask : t_stream

  task automatic t_modes();
    frame(1'b0, 2'b00, scp_pkg::ADDR_CFG, 1, 32'h99);
    host.sep = 1'b1;
    oe_seen  = 1'b0;
    frame(1'b1, 2'b00, scp_pkg::ADDR_CFG, 1, 32'h0);
    chk({oe_seen, rv[30:0]}, 32'h99);
    frame(1'b0, 2'b00, scp_pkg::ADDR_CFG, 1, 32'h18);
    host.sep = 1'b0;
    frame(1'b0, 2'b00, scp_pkg::ADDR_RBCTL, 1, 32'h01);
    frame(1'b0, 2'b00, scp_pkg::ADDR_UPDATE, 1, 32'h01);
    frame(1'b0, 2'b00, 10'h012, 1, 32'h5C);
    frame(1'b1, 2'b00, 10'h012, 1, 32'h0);
    chk(rv, 32'hA1);
    frame(1'b0, 2'b00, scp_pkg::ADDR_RBCTL, 1, 32'h00);
    frame(1'b0, 2'b00, scp_pkg::ADDR_UPDATE, 1, 32'h01);
    frame(1'b0, 2'b00, 10'h012, 1, 32'h6D);
    frame(1'b1, 2'b00, 10'h012, 1, 32'h0);
    chk(rv, 32'h6D);
    act_chk(10'h012, 8'h5C);
    frame(1'b0, 2'b00, scp_pkg::ADDR_CFG, 1, 32'h3C);
    frame(1'b1, 2'b00, scp_pkg::ADDR_CFG, 1, 32'h0);
    chk(rv, 32'h3C);
    frame(1'b0, 2'b00, scp_pkg::ADDR_CFG, 1, 32'h18);
    act_chk(10'h012, 8'h00);
    frame(1'b1, 2'b00, 10'h012, 1, 32'h0);
    chk(rv, 32'h0);
    $display("test modes done");
  endtask : t_modes

  task automatic t_reset();
    frame(1'b0, 2'b00, scp_pkg::ADDR_CFG, 1, 32'h99);
    frame(1'b0, 2'b00, 10'h012, 1, 32'h42);
    frame(1'b0, 2'b00, scp_pkg::ADDR_UPDATE, 1, 32'h01);
    act_chk(10'h012, 8'h42);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    act_chk(10'h012, 8'h00);
    frame(1'b1, 2'b00, scp_pkg::ADDR_CFG, 1, 32'h0);
    chk(rv, {24'h0, scp_pkg::CFG_RESET});
    $display("test reset done");
  endtask : t_reset

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    act_chk(10'h010, 8'h00);
    t_write_update();
    t_stall_abort();
    t_stream();
    t_modes();
    t_reset();
    end_sim();
  end
endmodule : scp_serial_port_bench
